// >>> rtl/status_lamp_driver.sv
// Front-panel lamp driver for a three-phase measurement module
`default_nettype none
// What this block does
// - Run lamp dark while the slave is in its startup state.
// - Run lamp flashes rapidly in the firmware load state.
// - Run lamp flashes at normal rate in the configuration state.
// - Run lamp gives a single flash in the safe output state.
// - Run lamp lit steadily in the running state.
// - Green health lamp follows the system healthy flag.
// - Voltage good lamp steady when phase voltage is normal.
// - Voltage good lamp flashes when phase voltage passed warning threshold.
// - Voltage fault lamp lit when phase voltage passed error threshold.
// - Current good lamp steady when phase current is normal.
// - Current good lamp flashes when phase current passed warning threshold.
// - Current fault lamp lit when phase current passed error threshold.
module status_lamp_driver
	import lamp_pkg::*;
#(
	parameter int unsigned PHASES      = PHASES_DEF,
	parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF
) (
	input  wire logic              clock_i,
	input  wire logic              sys_rst_i,
	input  wire slave_state_t      slave_state_i,
	input  wire logic              system_ok_i,
	input  wire logic [PHASES-1:0] voltage_warn_i,
	input  wire logic [PHASES-1:0] voltage_err_i,
	input  wire logic [PHASES-1:0] current_warn_i,
	input  wire logic [PHASES-1:0] current_err_i,
	output logic                   run_lamp_o,
	output logic                   health_lamp_o,
	output logic      [PHASES-1:0] phase_voltage_good_lamp_o,
	output logic      [PHASES-1:0] phase_voltage_fault_lamp_o,
	output logic      [PHASES-1:0] phase_current_good_lamp_o,
	output logic      [PHASES-1:0] phase_current_fault_lamp_o
);

	typedef struct packed {
		logic [TICK_W-1:0] tick_cnt;
		logic [STEP_W-1:0] step;
		logic              run;
		logic              health;
		logic [PHASES-1:0] v_good;
		logic [PHASES-1:0] v_fault;
		logic [PHASES-1:0] c_good;
		logic [PHASES-1:0] c_fault;
	} lamp_state_t;

	lamp_state_t s;
	lamp_state_t next_s;

	logic step_tick;
	logic rapid_on;
	logic flash_on;
	logic single_on;

	// Patterns come from the registered step, so all lamps flash in phase
	assign rapid_on  = s.step[RAPID_BIT];
	assign flash_on  = s.step[FLASH_BIT];
	assign single_on = (s.step < STEP_W'(SINGLE_ON_STEPS));

	always_comb begin
		next_s    = s;
		step_tick = 1'h0;
		// Divider runs free, independent of bus state, so patterns never stall
		if (s.tick_cnt == TICK_W'(STEP_CYCLES - 1)) begin
			next_s.tick_cnt = RST_TICK;
			step_tick       = 1'h1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + TICK_W'(1);
		end
		if (step_tick) begin
			if (s.step == STEP_W'(STEPS_PER_FRAME - 1)) begin
				next_s.step = RST_STEP;
			end else begin
				next_s.step = s.step + STEP_W'(1);
			end
		end
		unique case (slave_state_i)
			startup_state:       next_s.run = LAMP_OFF;
			firmware_load_state: next_s.run = rapid_on;
			configuration_state: next_s.run = flash_on;
			safe_output_state:   next_s.run = single_on;
			running_state:       next_s.run = LAMP_ON;
			// An undefined code shows as a dark lamp rather than a false state
			default:             next_s.run = LAMP_OFF;
		endcase
		next_s.health = system_ok_i;
		for (int i = 0; i < PHASES; i++) begin
			// Error wins over warning: a red lamp never sits beside a green one
			next_s.v_fault[i] = voltage_err_i[i];
			next_s.c_fault[i] = current_err_i[i];
			if (voltage_err_i[i]) begin
				next_s.v_good[i] = LAMP_OFF;
			end else if (voltage_warn_i[i]) begin
				next_s.v_good[i] = flash_on;
			end else begin
				next_s.v_good[i] = LAMP_ON;
			end
			if (current_err_i[i]) begin
				next_s.c_good[i] = LAMP_OFF;
			end else if (current_warn_i[i]) begin
				next_s.c_good[i] = flash_on;
			end else begin
				next_s.c_good[i] = LAMP_ON;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s.tick_cnt <= RST_TICK;
			s.step     <= RST_STEP;
			s.run      <= LAMP_OFF;
			s.health   <= LAMP_OFF;
			s.v_good   <= '0;
			s.v_fault  <= '0;
			s.c_good   <= '0;
			s.c_fault  <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign run_lamp_o                 = s.run;
	assign health_lamp_o              = s.health;
	assign phase_voltage_good_lamp_o  = s.v_good;
	assign phase_voltage_fault_lamp_o = s.v_fault;
	assign phase_current_good_lamp_o  = s.c_good;
	assign phase_current_fault_lamp_o = s.c_fault;

	// Checks
	// Antecedents need reset low when sampled: the first edge after release
	// still shows reset values, so a check ending there would fire falsely
	sequence seq_in_startup;
		!sys_rst_i && slave_state_i == startup_state;
	endsequence

	sequence seq_in_boot;
		!sys_rst_i && slave_state_i == firmware_load_state;
	endsequence

	sequence seq_in_config;
		!sys_rst_i && slave_state_i == configuration_state;
	endsequence

	sequence seq_in_safe;
		!sys_rst_i && slave_state_i == safe_output_state;
	endsequence

	sequence seq_run_held;
		(!sys_rst_i && slave_state_i == running_state) [*2];
	endsequence

	sequence seq_in_undefined;
		!sys_rst_i && !(slave_state_i inside {startup_state, configuration_state,
			safe_output_state, running_state, firmware_load_state});
	endsequence

	sequence seq_tick_last;
		!sys_rst_i && s.tick_cnt == TICK_W'(STEP_CYCLES - 1);
	endsequence

	a_run_startup_dark: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_in_startup |=> !run_lamp_o
	) else $error("run lamp lit in startup state");

	a_run_boot_rapid: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_in_boot |=> run_lamp_o == $past(s.step[RAPID_BIT])
	) else $error("run lamp not rapid flashing in firmware load");

	a_run_config_flash: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_in_config |=> run_lamp_o == $past(s.step[FLASH_BIT])
	) else $error("run lamp not flashing in configuration state");

	a_run_safe_single: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_in_safe |=> run_lamp_o == ($past(s.step) < STEP_W'(SINGLE_ON_STEPS))
	) else $error("run lamp not single flashing in safe output");

	a_run_op_steady: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_run_held |=> run_lamp_o [*1]
	) else $error("run lamp not steady in running state");

	a_health_follows: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!sys_rst_i |=> health_lamp_o == $past(system_ok_i)
	) else $error("health lamp does not follow system flag");

	a_step_on_tick: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		$changed(s.step) |-> $past(s.tick_cnt) == TICK_W'(STEP_CYCLES - 1)
	) else $error("flash step moved without divider tick");

	a_step_wraps: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		s.step < STEP_W'(STEPS_PER_FRAME)
	) else $error("flash step beyond frame length");

	a_run_undefined_dark: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_in_undefined |=> !run_lamp_o
	) else $error("run lamp lit for an undefined slave state");

	a_tick_in_range: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		s.tick_cnt < TICK_W'(STEP_CYCLES)
	) else $error("divider count beyond step length");

	a_tick_advances: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!sys_rst_i && s.tick_cnt != TICK_W'(STEP_CYCLES - 1) |=>
			s.tick_cnt == $past(s.tick_cnt) + TICK_W'(1)
	) else $error("divider did not count up");

	a_tick_wraps: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_tick_last |=> s.tick_cnt == RST_TICK
	) else $error("divider did not wrap at step end");

	a_step_advances: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_tick_last ##0 s.step != STEP_W'(STEPS_PER_FRAME - 1) |=>
			s.step == $past(s.step) + STEP_W'(1)
	) else $error("flash step did not advance on divider tick");

	a_step_frame_wrap: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		seq_tick_last ##0 s.step == STEP_W'(STEPS_PER_FRAME - 1) |=> s.step == RST_STEP
	) else $error("flash step did not wrap at frame end");

	a_step_holds: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!sys_rst_i && !step_tick |=> $stable(s.step)
	) else $error("flash step moved between divider ticks");

	// No disable here: this one watches the reset itself
	a_reset_dark: assert property (
		@(posedge clock_i)
		sys_rst_i |=> !run_lamp_o && !health_lamp_o &&
			phase_voltage_good_lamp_o == '0 && phase_voltage_fault_lamp_o == '0 &&
			phase_current_good_lamp_o == '0 && phase_current_fault_lamp_o == '0
	) else $error("lamps not dark after reset");

	for (genvar g = 0; g < PHASES; g++) begin : g_phase_checks
		a_volt_normal: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && !voltage_warn_i[g] && !voltage_err_i[g] |=>
				phase_voltage_good_lamp_o[g] && !phase_voltage_fault_lamp_o[g]
		) else $error("voltage good lamp not steady when normal");

		a_volt_warn_flash: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && voltage_warn_i[g] && !voltage_err_i[g] |=>
				phase_voltage_good_lamp_o[g] == $past(s.step[FLASH_BIT])
		) else $error("voltage good lamp not flashing on warning");

		a_volt_err_red: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && voltage_err_i[g] |=> phase_voltage_fault_lamp_o[g]
		) else $error("voltage fault lamp dark on error");

		a_curr_normal: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && !current_warn_i[g] && !current_err_i[g] |=>
				phase_current_good_lamp_o[g] && !phase_current_fault_lamp_o[g]
		) else $error("current good lamp not steady when normal");

		a_curr_warn_flash: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && current_warn_i[g] && !current_err_i[g] |=>
				phase_current_good_lamp_o[g] == $past(s.step[FLASH_BIT])
		) else $error("current good lamp not flashing on warning");

		a_curr_err_red: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && current_err_i[g] |=> phase_current_fault_lamp_o[g]
		) else $error("current fault lamp dark on error");

		a_green_red_excl: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!(phase_voltage_good_lamp_o[g] && phase_voltage_fault_lamp_o[g]) &&
			!(phase_current_good_lamp_o[g] && phase_current_fault_lamp_o[g])
		) else $error("good and fault lamps lit together");

		a_volt_green_off: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && voltage_err_i[g] |=> !phase_voltage_good_lamp_o[g]
		) else $error("voltage good lamp lit on error");

		a_curr_green_off: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && current_err_i[g] |=> !phase_current_good_lamp_o[g]
		) else $error("current good lamp lit on error");

		a_volt_fault_clear: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && !voltage_err_i[g] |=> !phase_voltage_fault_lamp_o[g]
		) else $error("voltage fault lamp lit without error");

		a_curr_fault_clear: assert property (
			@(posedge clock_i) disable iff (sys_rst_i)
			!sys_rst_i && !current_err_i[g] |=> !phase_current_fault_lamp_o[g]
		) else $error("current fault lamp lit without error");
	end

endmodule // status_lamp_driver
`default_nettype wire

// >>> rtl/lamp_pkg.sv
// Constants and types shared by the status lamp driver
`default_nettype none
package lamp_pkg;
	// Clock rate
	localparam int unsigned CLOCK_PERIOD_NS = 100;
	// Base flash step, 50 ms
	localparam int unsigned STEP_TIME_NS = 50_000_000;
	localparam int unsigned STEP_CYCLES_DEF = STEP_TIME_NS / CLOCK_PERIOD_NS;
	localparam int unsigned TICK_W = 20;
	// Pattern frame of 24 steps, 1.2 s
	localparam int unsigned STEP_W = 5;
	localparam int unsigned STEPS_PER_FRAME = 24;
	// Single flash: lit for the first 4 steps of a frame
	localparam int unsigned SINGLE_ON_STEPS = 4;
	// Rapid flash toggles every step, normal flash every 4 steps
	localparam int unsigned RAPID_BIT = 0;
	localparam int unsigned FLASH_BIT = 2;
	localparam int unsigned PHASES_DEF = 3;
	// Reset values
	localparam logic [TICK_W-1:0] RST_TICK = 20'h00000;
	localparam logic [STEP_W-1:0] RST_STEP = 5'h00;
	localparam logic LAMP_OFF = 1'h0;
	localparam logic LAMP_ON = 1'h1;
	// Fieldbus slave state, Gray coded along the usual start-up path
	typedef enum logic [2:0] {
		startup_state        = 3'h0,
		configuration_state  = 3'h1,
		safe_output_state    = 3'h3,
		running_state        = 3'h2,
		firmware_load_state  = 3'h6
	} slave_state_t;
endpackage : lamp_pkg
`default_nettype wire

// >>> verification/bus_master_model.sv
// Fieldbus master model that walks the slave through its states
`default_nettype none
module bus_master_model
	import lamp_pkg::*;
(
	input  wire logic       clock_i,
	output var slave_state_t state_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial state_o = startup_state;
	// Moves land just after an edge so the block never sees a half-made change
	task automatic go(input slave_state_t s);
		@(posedge clock_i);
		state_o <= s;
	endtask
endmodule // bus_master_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the status lamp driver
`default_nettype none
module tb
	import lamp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Short step so a whole pattern frame fits in about a hundred cycles
	localparam int SC    = 4;
	localparam int FRAME = SC * STEPS_PER_FRAME;
	logic         clock_i     = 1'h0;
	logic         sys_rst_i   = 1'h1;
	logic         system_ok_i = 1'h0;
	logic   [2:0] vw = 3'h0, ve = 3'h0, cw = 3'h0, ce = 3'h0;
	slave_state_t slave_state;
	logic         run, health;
	logic   [2:0] vg, vf, cg, cf;
	logic  [13:0] lamps;
	int           errors = 0, checked = 0;
	int           lit_c [14], chg_c [14];
	assign lamps = {run, health, vg, vf, cg, cf};
	initial forever #50 clock_i = ~clock_i;
	bus_master_model master (.clock_i(clock_i), .state_o(slave_state));
	status_lamp_driver #(.PHASES(3), .STEP_CYCLES(SC)) uut (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slave_state_i(slave_state),
		.system_ok_i(system_ok_i), .voltage_warn_i(vw), .voltage_err_i(ve),
		.current_warn_i(cw), .current_err_i(ce), .run_lamp_o(run), .health_lamp_o(health),
		.phase_voltage_good_lamp_o(vg), .phase_voltage_fault_lamp_o(vf),
		.phase_current_good_lamp_o(cg), .phase_current_fault_lamp_o(cf));
	task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Counting over one whole frame makes the result independent of the phase
	task automatic measure();
		logic [13:0] prev;
		prev = lamps;
		for (int i = 0; i < 14; i++) begin
			lit_c[i] = 0;
			chg_c[i] = 0;
		end
		repeat (FRAME) begin
			@(posedge clock_i);
			#1;
			for (int i = 0; i < 14; i++) begin
				lit_c[i] += int'(lamps[i] === 1'h1);
				chg_c[i] += int'(lamps[i] !== prev[i]);
			end
			prev = lamps;
		end
	endtask
	task automatic pat(input string what, input int idx, input int lit, input int chg);
		checked++;
		if (lit_c[idx] != lit || chg_c[idx] != chg) begin
			errors++;
			$display("ERROR %s expected %0d/%0d seen %0d/%0d", what, lit, chg, lit_c[idx],
				chg_c[idx]);
		end
	endtask
	task automatic test_latency();
		master.go(running_state);
		system_ok_i <= 1'h1;
		#1;
		check("lamps before update", 14'h0e38, lamps);
		@(posedge clock_i);
		system_ok_i <= 1'h0;
		#1;
		check("run and health on", 14'h3e38, lamps);
		repeat (2) @(posedge clock_i);
		#1;
		check("health off", 14'h2e38, lamps);
		$display("latency test done");
	endtask
	task automatic test_run_states();
		slave_state_t st [6] = '{startup_state, firmware_load_state, configuration_state,
			safe_output_state, running_state, slave_state_t'(3'h7)};
		int lit [6] = '{0, FRAME / 2, FRAME / 2, SINGLE_ON_STEPS * SC, FRAME, 0};
		int chg [6] = '{0, STEPS_PER_FRAME, STEPS_PER_FRAME / 4, 2, 0, 0};
		for (int i = 0; i < 6; i++) begin
			master.go(st[i]);
			repeat (2) @(posedge clock_i);
			#1;
			measure();
			pat("run lamp", 13, lit[i], chg[i]);
		end
		$display("run lamp test done");
	endtask
	task automatic test_phases();
		@(posedge clock_i);
		vw <= 3'h3;
		ve <= 3'h2;
		cw <= 3'h5;
		ce <= 3'h1;
		repeat (2) @(posedge clock_i);
		#1;
		measure();
		pat("voltage good 0", 9, FRAME / 2, STEPS_PER_FRAME / 4);
		pat("voltage good 1", 10, 0, 0);
		pat("voltage good 2", 11, FRAME, 0);
		pat("voltage fault 0", 6, 0, 0);
		pat("voltage fault 1", 7, FRAME, 0);
		pat("current good 0", 3, 0, 0);
		pat("current good 1", 4, FRAME, 0);
		pat("current good 2", 5, FRAME / 2, STEPS_PER_FRAME / 4);
		pat("current fault 0", 0, FRAME, 0);
		pat("current fault 2", 2, 0, 0);
		$display("phase lamp test done");
	endtask
	// Reset in mid-run: lamps go dark and the divider restarts at the frame start
	task automatic test_reset();
		master.go(safe_output_state);
		system_ok_i <= 1'h1;
		sys_rst_i   <= 1'h1;
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'h0;
		#1;
		check("lamps in mid-run reset", 14'h0000, lamps);
		@(posedge clock_i);
		#1;
		check("lamps after reset", 14'h3891, lamps);
		repeat (SINGLE_ON_STEPS * SC - 1) @(posedge clock_i);
		#1;
		check("single flash last lit", 14'h0001, {13'h0000, run});
		@(posedge clock_i);
		#1;
		check("single flash first dark", 14'h0000, {13'h0000, run});
		$display("reset test done");
	endtask
	task automatic give_verdict();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'h0;
		#1;
		check("lamps in reset", 14'h0000, lamps);
		@(posedge clock_i);
		#1;
		check("lamps at release", 14'h0e38, lamps);
		test_latency();
		test_run_states();
		test_phases();
		test_reset();
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge clock_i);
		errors++;
		give_verdict();
	end
endmodule // tb
`default_nettype wire
